// ==== frc_defines.svh ====
// register offsets, field positions and reset values of the capture/compare timer
`ifndef FRC_DEFINES_SVH
`define FRC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets (one byte register per 32-bit word)
// ----------------------------------------------------------------------------
`define OFS_COUNT_HI   8'h00
`define OFS_COUNT_LO   8'h04
`define OFS_CMP_HI     8'h08
`define OFS_CMP_LO     8'h0C
`define OFS_CAP_A_HI   8'h10
`define OFS_CAP_A_LO   8'h14
`define OFS_CAP_B_HI   8'h18
`define OFS_CAP_B_LO   8'h1C
`define OFS_CAP_C_HI   8'h20
`define OFS_CAP_C_LO   8'h24
`define OFS_CAP_D_HI   8'h28
`define OFS_CAP_D_LO   8'h2C
`define OFS_STATUS     8'h30
`define OFS_IRQ_EN     8'h34
`define OFS_CONTROL    8'h38
`define OFS_OUT_CTRL   8'h3C

// ----------------------------------------------------------------------------
// status / enable field positions (flags in 7..1, clear_on_match_a in 0)
// ----------------------------------------------------------------------------
`define FLG_CAP_A      7
`define FLG_CAP_B      6
`define FLG_CAP_C      5
`define FLG_CAP_D      4
`define FLG_CMP_A      3
`define FLG_CMP_B      2
`define FLG_WRAP       1
`define BIT_CLR_ON_A   0

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define CTL_EDGE_A     7
`define CTL_EDGE_B     6
`define CTL_EDGE_C     5
`define CTL_EDGE_D     4
`define CTL_BUF_A      3
`define CTL_BUF_B      2
`define CTL_CKS_HI     1
`define CTL_CKS_LO     0
`define OCT_CMP_SEL    4
`define OCT_OE_A       3
`define OCT_OE_B       2
`define OCT_LVL_A      1
`define OCT_LVL_B      0

// ----------------------------------------------------------------------------
// clock select codes and prescaler taps
// ----------------------------------------------------------------------------
`define CKS_DIV2       2'h0
`define CKS_DIV8       2'h1
`define CKS_DIV32      2'h2
`define CKS_EXT        2'h3
`define TAP_DIV2       0
`define TAP_DIV8       2
`define TAP_DIV32      4

// ----------------------------------------------------------------------------
// reset values, reserved read bits and counter maximum
// ----------------------------------------------------------------------------
`define RST_COUNT      16'h0000
`define RST_CMP        16'hFFFF
`define RST_CAP        16'h0000
`define RST_CONTROL    8'h00
`define OUT_CTRL_RSVD  8'hE0
`define COUNT_MAX      16'hFFFF

`endif

// ==== frc_monitor.sv ====
// port checker for the capture/compare timer
`default_nettype none
module frc_monitor (
    input wire logic                mclk,
    input wire logic                resetn,
    input wire frc_pkg::wb_req_type wb_req,
    input wire frc_pkg::wb_rsp_type wb_rsp,
    input wire frc_pkg::irq_type    irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic rd_ack;
    logic wr_flag;
    assign rd_ack  = wb_rsp.ack && !wb_req.we;
    // writes to status or enable are the only ways a request may drop
    assign wr_flag = wb_rsp.ack && wb_req.we && wb_req.sel[0]
                     && (wb_req.adr == 8'h30 || wb_req.adr == 8'h34);
    // ------------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------------
    property p_ack_cause; wb_rsp.ack |-> wb_req.cyc && wb_req.stb; endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_ack_pulse; wb_rsp.ack |=> !wb_rsp.ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_answer; $rose(wb_req.cyc && wb_req.stb) |=> wb_rsp.ack; endproperty
    a_answer: assert property (p_answer) else $error("ack late");
    property p_dat_hi; wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h000000; endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("upper read data not zero");
    property p_rsvd; rd_ack && wb_req.adr == 8'h3C |-> wb_rsp.dat[7:5] == 3'h7; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not one");
    property p_unmapped; rd_ack && wb_req.adr > 8'h3C |-> wb_rsp.dat == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_any; irq.any == (irq.line != 7'h00); endproperty
    a_any: assert property (p_any) else $error("any flag wrong");
    property p_prio; irq.any |-> (irq.line >> irq.top) == 7'h01; endproperty
    a_prio: assert property (p_prio) else $error("top request wrong");
    property p_clear; ($past(irq.line) & ~irq.line) != 7'h00 |-> $past(wr_flag); endproperty
    a_clear: assert property (p_clear) else $error("request dropped unasked");
    c_read: cover property (rd_ack);
    c_flag_write: cover property (wr_flag);
    c_cap_top: cover property (irq.any && irq.top == 3'h6);
endmodule : frc_monitor
`default_nettype wire

// ==== frc_pin_model.sv ====
// far-side pin driver: capture inputs and external count clock
`default_nettype none
module frc_pin_model (
    input  wire logic      mclk,
    output var logic [4:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = 5'h00;
    // pins 0..3 capture a..d, pin 4 external clock; w >= 2 holds each level at least 2 clocks
    task automatic toggle(input int p, input int n, input int w);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            pins[p] <= ~pins[p];
            repeat (w - 1) @(posedge mclk);
        end
    endtask : toggle
endmodule : frc_pin_model
`default_nettype wire

// ==== frc_pkg.sv ====
// types shared by the capture/compare timer
`default_nettype none

package frc_pkg;

    // ------------------------------------------------------------------------
    // wishbone request and answer
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_type;

    // irq lines: 6 cap a,5 cap b,4 cap c,3 cap d,2 cmp a,1 cmp b,0 wrap
    typedef struct packed {
        logic [6:0] line;
        logic [2:0] top;
        logic       any;
    } irq_type;

    // ------------------------------------------------------------------------
    // whole module state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [4:0]       prescale;
        logic             src_prev;
        logic [15:0]      counter;
        logic [15:0]      cmp_a;
        logic [15:0]      cmp_b;
        logic [3:0][15:0] cap;
        logic [7:0]       temp;
        logic [6:0]       flags;
        logic [6:0]       ien;
        logic             clr_on_a;
        logic [7:0]       control;
        logic [4:0]       out_ctrl;
        logic [3:0]       pin_prev;
        logic [3:0]       pend;
        logic [3:0]       sec_pend;
        logic             out_a;
        logic             out_b;
        logic             ack;
        logic [7:0]       rdata;
    } state_type;

endpackage : frc_pkg

`default_nettype wire

// ==== free_running_capture_compare.sv ====
// 16-bit free counter with two compare and four capture channels, wishbone slave
//
// Our own choices: the register offsets and the Wishbone slave port.
`include "frc_defines.svh"
`default_nettype none

module free_running_capture_compare (
    input  wire logic               mclk,
    input  wire logic               resetn,
    input  wire frc_pkg::wb_req_type wb_req,
    output frc_pkg::wb_rsp_type     wb_rsp,
    input  wire logic               ext_count_clock_pin,
    input  wire logic               capture_pin_a,
    input  wire logic               capture_pin_b,
    input  wire logic               capture_pin_c,
    input  wire logic               capture_pin_d,
    output logic                    compare_out_pin_a,
    output logic                    compare_out_enable_a,
    output logic                    compare_out_pin_b,
    output logic                    compare_out_enable_b,
    output frc_pkg::irq_type        irq
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic edge_hit(input logic sel, input logic rise, input logic fall);
        edge_hit = sel ? rise : fall;
    endfunction : edge_hit

    // index of the highest pending line: bit 6 is capture a, highest
    function automatic logic [2:0] top_irq(input logic [6:0] req);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 0; i < 7; i++) begin
            if (req[i]) begin
                idx = 3'(i);
            end
        end
        top_irq = idx;
    endfunction : top_irq

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    frc_pkg::state_type state_r;
    frc_pkg::state_type state_nxt;

    logic       req_new;
    logic       wr_take;
    logic       rd_new;
    logic [7:0] wbyte;
    logic [1:0] cks;
    logic       src_lvl;
    logic       count_pulse;
    logic       match_a;
    logic       match_b;
    logic       cmp_lo_wr;
    logic       cnt_lo_wr;
    logic       clr_evt;
    logic [3:0] pins;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [3:0] own_evt;
    logic [3:0] busy;
    logic [3:0] strobe;
    logic [3:0] sec_strobe;
    logic [1:0] bufm;
    logic [6:0] set_flags;
    logic [7:0] rd_byte;
    logic       unused_bits;

    assign pins = {capture_pin_d, capture_pin_c, capture_pin_b, capture_pin_a};
    assign bufm = {state_r.control[`CTL_BUF_B], state_r.control[`CTL_BUF_A]};
    assign cks  = state_r.control[`CTL_CKS_HI:`CTL_CKS_LO];
    assign unused_bits = ^{wb_req.dat[31:8], wb_req.sel[3:1], wb_req.adr[1:0]};

    always_comb begin
        // --------------------------------------------------------------------
        // bus decode: ack one cycle after request, write lands at ack edge
        // --------------------------------------------------------------------
        req_new   = wb_req.cyc & wb_req.stb & ~state_r.ack;
        wr_take   = wb_req.cyc & wb_req.stb & wb_req.we & state_r.ack & wb_req.sel[0];
        rd_new    = req_new & ~wb_req.we;
        wbyte     = wb_req.dat[7:0];
        cnt_lo_wr = wr_take & (wb_req.adr == `OFS_COUNT_LO);
        cmp_lo_wr = wr_take & (wb_req.adr == `OFS_CMP_LO);

        // --------------------------------------------------------------------
        // count source: free prescaler, selection is only a tap
        // --------------------------------------------------------------------
        case (cks)
            `CKS_DIV2:  src_lvl = state_r.prescale[`TAP_DIV2];
            `CKS_DIV8:  src_lvl = state_r.prescale[`TAP_DIV8];
            `CKS_DIV32: src_lvl = state_r.prescale[`TAP_DIV32];
            // inverted so a rising pin edge is a falling source edge
            `CKS_EXT:   src_lvl = ~ext_count_clock_pin;
            default:    src_lvl = 1'b0;
        endcase
        // a select change from high to low looks like a falling edge too
        count_pulse = state_r.src_prev & ~src_lvl;

        // --------------------------------------------------------------------
        // compare: last equal state just before advance
        // --------------------------------------------------------------------
        match_a = count_pulse & (state_r.counter == state_r.cmp_a)
                  & ~(cmp_lo_wr & ~state_r.out_ctrl[`OCT_CMP_SEL]);
        match_b = count_pulse & (state_r.counter == state_r.cmp_b)
                  & ~(cmp_lo_wr & state_r.out_ctrl[`OCT_CMP_SEL]);
        clr_evt = match_a & state_r.clr_on_a;

        // --------------------------------------------------------------------
        // capture edges, busy windows and strobes
        // --------------------------------------------------------------------
        rise = pins & ~state_r.pin_prev;
        fall = ~pins & state_r.pin_prev;
        for (int i = 0; i < 4; i++) begin
            own_evt[i] = edge_hit(state_r.control[`CTL_EDGE_A - i], rise[i], fall[i]);
            busy[i]    = rd_new & (wb_req.adr == (`OFS_CAP_A_HI + 8'(8 * i)));
        end
        for (int p = 0; p < 2; p++) begin
            if (bufm[p]) begin
                // secondary select adds a second edge on the primary pin
                own_evt[p] = own_evt[p] | edge_hit(state_r.control[`CTL_EDGE_C - p],
                                                   rise[p], fall[p]);
                busy[p]    = busy[p] | busy[p + 2];
            end
        end
        for (int i = 0; i < 4; i++) begin
            strobe[i]     = (own_evt[i] | state_r.pend[i]) & ~busy[i];
            sec_strobe[i] = 1'b0;
        end
        for (int p = 0; p < 2; p++) begin
            if (bufm[p]) begin
                // secondary pin only flags, the register is the buffer
                sec_strobe[p + 2] = own_evt[p + 2];
                strobe[p + 2]     = 1'b0;
            end
        end

        // --------------------------------------------------------------------
        // read mux
        // --------------------------------------------------------------------
        case (wb_req.adr)
            `OFS_COUNT_HI: rd_byte = state_r.counter[15:8];
            `OFS_COUNT_LO: rd_byte = state_r.temp;
            `OFS_CMP_HI:   rd_byte = state_r.out_ctrl[`OCT_CMP_SEL] ?
                                     state_r.cmp_b[15:8] : state_r.cmp_a[15:8];
            `OFS_CMP_LO:   rd_byte = state_r.out_ctrl[`OCT_CMP_SEL] ?
                                     state_r.cmp_b[7:0] : state_r.cmp_a[7:0];
            `OFS_CAP_A_HI: rd_byte = state_r.cap[0][15:8];
            `OFS_CAP_B_HI: rd_byte = state_r.cap[1][15:8];
            `OFS_CAP_C_HI: rd_byte = state_r.cap[2][15:8];
            `OFS_CAP_D_HI: rd_byte = state_r.cap[3][15:8];
            `OFS_CAP_A_LO,
            `OFS_CAP_B_LO,
            `OFS_CAP_C_LO,
            `OFS_CAP_D_LO: rd_byte = state_r.temp;
            `OFS_STATUS:   rd_byte = {state_r.flags, state_r.clr_on_a};
            `OFS_IRQ_EN:   rd_byte = {state_r.ien, 1'b0};
            `OFS_CONTROL:  rd_byte = state_r.control;
            `OFS_OUT_CTRL: rd_byte = `OUT_CTRL_RSVD | {3'h0, state_r.out_ctrl};
            default:       rd_byte = 8'h00;
        endcase

        // --------------------------------------------------------------------
        // next state
        // --------------------------------------------------------------------
        state_nxt          = state_r;
        state_nxt.prescale = state_r.prescale + 5'h01;
        state_nxt.src_prev = src_lvl;
        state_nxt.pin_prev = pins;
        state_nxt.ack      = req_new;
        state_nxt.rdata    = req_new ? rd_byte : state_r.rdata;

        for (int i = 0; i < 4; i++) begin
            state_nxt.pend[i] = (own_evt[i] | state_r.pend[i]) & busy[i];
        end
        for (int p = 0; p < 2; p++) begin
            if (bufm[p]) begin
                state_nxt.pend[p + 2] = 1'b0;
            end
        end
        state_nxt.sec_pend = sec_strobe;

        // counter: clear beats write, write beats increment
        if (clr_evt) begin
            state_nxt.counter = `RST_COUNT;
        end else if (cnt_lo_wr) begin
            state_nxt.counter = {state_r.temp, wbyte};
        end else if (count_pulse) begin
            state_nxt.counter = state_r.counter + 16'h0001;
        end

        // capture loads; buffer shifts old primary into its pair
        for (int i = 0; i < 4; i++) begin
            if (strobe[i]) begin
                state_nxt.cap[i] = state_r.counter;
            end
        end
        for (int p = 0; p < 2; p++) begin
            if (bufm[p] && strobe[p]) begin
                state_nxt.cap[p + 2] = state_r.cap[p];
            end
        end

        // compare pins
        if (match_a) begin
            state_nxt.out_a = state_r.out_ctrl[`OCT_LVL_A];
        end
        if (match_b) begin
            state_nxt.out_b = state_r.out_ctrl[`OCT_LVL_B];
        end

        // event flags: a set in the clearing cycle still wins
        set_flags = {strobe[0], strobe[1], strobe[2] | sec_strobe[2],
                     strobe[3] | sec_strobe[3], match_a, match_b,
                     count_pulse & ~clr_evt & ~cnt_lo_wr
                     & (state_r.counter == `COUNT_MAX)};

        // register writes
        if (wr_take) begin
            case (wb_req.adr)
                `OFS_COUNT_HI,
                `OFS_CMP_HI:   state_nxt.temp = wbyte;
                `OFS_CMP_LO: begin
                    if (state_r.out_ctrl[`OCT_CMP_SEL]) begin
                        state_nxt.cmp_b = {state_r.temp, wbyte};
                    end else begin
                        state_nxt.cmp_a = {state_r.temp, wbyte};
                    end
                end
                `OFS_STATUS: begin
                    state_nxt.flags    = state_r.flags & wbyte[7:1];
                    state_nxt.clr_on_a = wbyte[`BIT_CLR_ON_A];
                end
                `OFS_IRQ_EN:   state_nxt.ien = wbyte[7:1];
                `OFS_CONTROL:  state_nxt.control = wbyte;
                `OFS_OUT_CTRL: state_nxt.out_ctrl = wbyte[4:0];
                default: begin
                end
            endcase
        end
        state_nxt.flags = state_nxt.flags | set_flags;

        // counter and capture upper reads stage the lower byte for the next lower read
        if (rd_new) begin
            case (wb_req.adr)
                `OFS_COUNT_HI: state_nxt.temp = state_r.counter[7:0];
                `OFS_CAP_A_HI: state_nxt.temp = state_r.cap[0][7:0];
                `OFS_CAP_B_HI: state_nxt.temp = state_r.cap[1][7:0];
                `OFS_CAP_C_HI: state_nxt.temp = state_r.cap[2][7:0];
                `OFS_CAP_D_HI: state_nxt.temp = state_r.cap[3][7:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_r          <= '0;
            state_r.counter  <= `RST_COUNT;
            state_r.cmp_a    <= `RST_CMP;
            state_r.cmp_b    <= `RST_CMP;
            state_r.cap      <= {4{`RST_CAP}};
            state_r.control  <= `RST_CONTROL;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign wb_rsp.ack = state_r.ack & wb_req.cyc & wb_req.stb;
    assign wb_rsp.dat = {24'h000000, state_r.rdata};

    assign compare_out_pin_a    = state_r.out_a;
    assign compare_out_pin_b    = state_r.out_b;
    assign compare_out_enable_a = state_r.out_ctrl[`OCT_OE_A];
    assign compare_out_enable_b = state_r.out_ctrl[`OCT_OE_B];

    assign irq.line = state_r.flags & state_r.ien;
    assign irq.top  = top_irq(state_r.flags & state_r.ien);
    assign irq.any  = |(state_r.flags & state_r.ien) | (unused_bits & 1'b0);

endmodule : free_running_capture_compare

`default_nettype wire

// ==== free_running_capture_compare_tb_top.sv ====
// self-checking bench for the capture/compare timer
`default_nettype none
module free_running_capture_compare_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                mclk;
    logic                resetn;
    frc_pkg::wb_req_type wb_req;
    frc_pkg::wb_rsp_type wb_rsp;
    frc_pkg::irq_type    irq;
    logic [4:0]          pins;
    logic [1:0]          cpin;
    logic [1:0]          coe;
    logic [15:0]         v0;
    logic [15:0]         v1;
    logic [15:0]         ca;
    logic [7:0]          q;
    int                  fail_count;
    int                  comparisons;
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;
    free_running_capture_compare dut_u (.mclk(mclk), .resetn(resetn),
        .wb_req(wb_req), .wb_rsp(wb_rsp), .ext_count_clock_pin(pins[4]),
        .capture_pin_a(pins[0]), .capture_pin_b(pins[1]), .capture_pin_c(pins[2]),
        .capture_pin_d(pins[3]), .compare_out_pin_a(cpin[0]),
        .compare_out_enable_a(coe[0]), .compare_out_pin_b(cpin[1]),
        .compare_out_enable_b(coe[1]), .irq(irq));
    frc_pin_model pm_u (.mclk(mclk), .pins(pins));
    // ------------------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge mclk);
        wb_req <= '{1'b1, 1'b1, w, 4'h1, a, {24'h000000, d}};
        // ack and read data are sampled at the same rising edge
        do begin
            @(posedge mclk);
            t++;
        end while (wb_rsp.ack !== 1'b1 && t < 50);
        q = wb_rsp.dat[7:0];
        if (t >= 50) fail_count++;
        wb_req <= '0;
    endtask : wb
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wb(a, 1'b1, v[15:8]);
        wb(a + 8'h04, 1'b1, v[7:0]);
    endtask : wr16
    // upper byte first, counter and capture lower bytes come from staging
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        wb(a, 1'b0, 8'h00);
        v[15:8] = q;
        wb(a + 8'h04, 1'b0, 8'h00);
        v[7:0] = q;
    endtask : rd16
    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        rd16(8'h08, v0);
        chk("compare", 16'hFFFF, v0);
        wb(8'h3C, 1'b0, 8'h00);
        chk("out control", 16'h00E0, {8'h00, q});
        wb(8'h38, 1'b0, 8'h00);
        chk("control", 16'h0000, {8'h00, q});
        wb(8'h40, 1'b0, 8'h00);
        chk("unmapped", 16'h0000, {8'h00, q});
    endtask : t_reset
    // snapshots exactly 256 clocks apart, a multiple of every tap period
    task automatic t_rate;
        for (int k = 0; k < 3; k++) begin
            if (k > 0) wb(8'h38, 1'b1, k[7:0]);
            rd16(8'h00, v0);
            repeat (250) @(posedge mclk);
            rd16(8'h00, v1);
            chk("rate", 16'h0080 >> (2 * k), v1 - v0);
        end
    endtask : t_rate
    task automatic t_ext;
        wb(8'h38, 1'b1, 8'h03);
        repeat (4) @(posedge mclk);
        rd16(8'h00, v0);
        pm_u.toggle(4, 10, 2);
        rd16(8'h00, v1);
        chk("external", 16'h0005, v1 - v0);
    endtask : t_ext
    task automatic t_compare;
        wb(8'h38, 1'b1, 8'h00);
        wb(8'h3C, 1'b1, 8'h1F);
        wr16(8'h08, 16'h0040);
        wb(8'h3C, 1'b1, 8'h0F);
        wr16(8'h08, 16'h0020);
        wb(8'h34, 1'b1, 8'h0C);
        wb(8'h30, 1'b1, 8'h01);
        wr16(8'h00, 16'h0000);
        repeat (100) @(negedge mclk);
        chk("pins", 16'h0001, {14'h0000, cpin});
        chk("enables", 16'h0003, {14'h0000, coe});
        chk("irq", 16'h0004, {9'h000, irq.line});
        rd16(8'h00, v0);
        chk("cleared", 16'h0001, {15'h0000, v0 <= 16'h0020});
        wb(8'h30, 1'b0, 8'h00);
        chk("status", 16'h0009, {8'h00, q});
        wb(8'h30, 1'b1, 8'h00);
        repeat (200) @(negedge mclk);
        chk("pins", 16'h0003, {14'h0000, cpin});
        chk("top", 16'h0002, {13'h0000, irq.top});
        wb(8'h30, 1'b0, 8'h00);
        chk("status", 16'h000C, {8'h00, q});
    endtask : t_compare
    task automatic t_wrap;
        wb(8'h34, 1'b1, 8'h02);
        wr16(8'h00, 16'hFFF0);
        repeat (64) @(negedge mclk);
        chk("wrap irq", 16'h0001, {9'h000, irq.line});
        wb(8'h30, 1'b1, 8'hFE);
        @(negedge mclk);
        chk("kept", 16'h0001, {9'h000, irq.line});
        wb(8'h30, 1'b1, 8'h00);
        @(negedge mclk);
        chk("cleared", 16'h0000, {9'h000, irq.line});
    endtask : t_wrap
    task automatic t_capture;
        wb(8'h34, 1'b1, 8'hF0);
        wb(8'h38, 1'b1, 8'h80);
        rd16(8'h00, v0);
        pm_u.toggle(0, 1, 2);
        rd16(8'h00, v1);
        rd16(8'h10, ca);
        chk("window", 16'h0001, {15'h0000, ca >= v0 && ca <= v1});
        @(negedge mclk);
        chk("cap irq", 16'h0040, {9'h000, irq.line});
        chk("top", 16'h0006, {13'h0000, irq.top});
        pm_u.toggle(0, 1, 2);
        rd16(8'h10, v0);
        chk("falling", ca, v0);
    endtask : t_capture
    task automatic t_buffer;
        wb(8'h30, 1'b1, 8'h00);
        wb(8'h38, 1'b1, 8'h88);
        pm_u.toggle(0, 1, 2);
        rd16(8'h20, v0);
        chk("buffer", ca, v0);
        rd16(8'h10, v1);
        pm_u.toggle(0, 1, 2);
        rd16(8'h20, v0);
        chk("both edges", v1, v0);
        pm_u.toggle(2, 2, 2);
        rd16(8'h20, v0);
        chk("no load", v1, v0);
        wb(8'h30, 1'b0, 8'h00);
        chk("flags", 16'h00A0, {8'h00, q & 8'hA0});
    endtask : t_buffer
    task automatic summarize;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        fail_count = 0;
        comparisons = 0;
        resetn = 1'b0;
        wb_req = '0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_rate();
        t_ext();
        t_compare();
        t_wrap();
        t_capture();
        t_buffer();
        summarize();
    end
    // whole run is under 1400 clocks
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        summarize();
    end
endmodule : free_running_capture_compare_tb_top
bind free_running_capture_compare frc_monitor mon_u (.mclk(mclk), .resetn(resetn),
    .wb_req(wb_req), .wb_rsp(wb_rsp), .irq(irq));
`default_nettype wire
